// >>> src/parallel_io_regs.vh
// Register map, field widths and reset values of the three-port parallel I/O block.
// Included by the block's single design file; holds definitions only.
`ifndef PARALLEL_IO_REGS_VH
`define PARALLEL_IO_REGS_VH

// ***************************************
// Register indices (byte address = 4 * index)
// ***************************************
`define FIRST_PORT_LATCH_IDX 3'h0
`define SECOND_PORT_LATCH_IDX 3'h1
`define THIRD_PORT_LATCH_IDX 3'h2
`define UNUSED_GAP_IDX 3'h3
`define FIRST_PORT_DIRECTION_IDX 3'h4
`define SECOND_PORT_DIRECTION_IDX 3'h5
`define THIRD_PORT_DIRECTION_IDX 3'h6

// ***************************************
// Field widths and reset values
// ***************************************
`define WIDE_PORT_BITS 7
`define NARROW_PORT_BITS 2
`define DIRECTION_RESET_WIDE 7'h00
`define DIRECTION_RESET_NARROW 2'h0

// ***************************************
// AXI responses
// ***************************************
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// >>> src/three_port_parallel_io.v
// Three parallel ports (7, 7 and 2 pins) with latch and direction registers,
// reached over an AXI4-Lite slave. Pins arrive asynchronously and are
// synchronised here; the board resolves the pin wire from oe and out.
// Data latches carry no reset and read unknown on output bits in simulation until written;
// software loads them before it turns a pin to an output.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "parallel_io_regs.vh"

// Functional notes
// - Port A: seven general-purpose pins, bits 6..0 of its data register.
// - Port B: seven bidirectional pins, also shared with serial interface.
// - Port A and B output latches are read/write and never reset.
// - Direction bit 1 enables pin output buffer; 0 leaves pin an input.
// - Reset clears all port A and B direction bits to zero.
// - Port A data read: latch where direction is 1, pin level otherwise.
// - Port B data read: latch for outputs, pin level for inputs.
// - Data writes with lane 0 enabled update latch; input bits still read pin level.
// - Direction bit 0 turns the pin driver off, pin high impedance.
// - Port C output bit forces its fault input to non-fault state.
// - Port C data read: latch for outputs, pin level for inputs.
module three_port_parallel_io #(
   parameter WIDE_BITS = `WIDE_PORT_BITS,
   parameter NARROW_BITS = `NARROW_PORT_BITS
) (
   // Clock and reset
   input wire ref_clk,
   input wire resetn,
   // AXI4-Lite write address
   input wire [4:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [4:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   // First port pins
   input wire [WIDE_BITS-1:0] firstPortIn,
   output wire [WIDE_BITS-1:0] firstPortOut,
   output wire [WIDE_BITS-1:0] firstPortOe,
   // Second port pins, shared with the serial interface
   input wire [WIDE_BITS-1:0] secondPortIn,
   output wire [WIDE_BITS-1:0] secondPortOut,
   output wire [WIDE_BITS-1:0] secondPortOe,
   // Third port pins
   input wire [NARROW_BITS-1:0] thirdPortIn,
   output wire [NARROW_BITS-1:0] thirdPortOut,
   output wire [NARROW_BITS-1:0] thirdPortOe,
   // Fault inputs toward the motor PWM (bit 0 = input one, bit 1 = input four)
   output wire [NARROW_BITS-1:0] motorFaultInput
);

   // ***************************************
   // Functions
   // ***************************************
   // Per-bit read mux: latch where output, pin where input
   function [WIDE_BITS-1:0] pinView;
      input [WIDE_BITS-1:0] latchVal;
      input [WIDE_BITS-1:0] pinVal;
      input [WIDE_BITS-1:0] dirVal;
      begin
         pinView = (latchVal & dirVal) | (pinVal & ~dirVal);
      end
   endfunction

   // Byte address to register index; bits above the map are kept for decode
   function [2:0] regIndex;
      input [4:0] byteAddr;
      begin
         regIndex = byteAddr[4:2];
      end
   endfunction

   // ***************************************
   // Storage
   // ***************************************
   // Software-visible latches and direction bits
   reg [WIDE_BITS-1:0] firstLatch_ff;
   reg [WIDE_BITS-1:0] secondLatch_ff;
   reg [NARROW_BITS-1:0] thirdLatch_ff;
   reg [WIDE_BITS-1:0] firstDir_ff;
   reg [WIDE_BITS-1:0] secondDir_ff;
   reg [NARROW_BITS-1:0] thirdDir_ff;

   // Two synchroniser stages per pin
   reg [WIDE_BITS-1:0] firstSyncA_ff;
   reg [WIDE_BITS-1:0] firstSyncB_ff;
   reg [WIDE_BITS-1:0] secondSyncA_ff;
   reg [WIDE_BITS-1:0] secondSyncB_ff;
   reg [NARROW_BITS-1:0] thirdSyncA_ff;
   reg [NARROW_BITS-1:0] thirdSyncB_ff;

   // Write channel: address and data held until both halves are here
   reg [4:0] awAddr_ff;
   reg awHeld_ff;
   reg [31:0] wData_ff;
   reg [3:0] wStrb_ff;
   reg wHeld_ff;
   reg bValid_ff;
   reg [1:0] bResp_ff;

   // Read answer, held until rready
   reg rValid_ff;
   reg [31:0] rData_ff;
   reg [1:0] rResp_ff;

   // Combinational read decode
   reg [31:0] nxt_rData;
   reg nxt_rHit;

   // Write and read decode
   wire doWrite;
   wire doStore;
   wire [2:0] wIdx;
   wire wHit;
   wire [2:0] rIdx;

   // ***************************************
   // Pin synchronisers
   // ***************************************
   // Two stages; only the second stage feeds the read mux and fault logic
   // Cleared by reset so the fault inputs start in the non-fault state
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         firstSyncA_ff <= {WIDE_BITS{1'b0}};
         firstSyncB_ff <= {WIDE_BITS{1'b0}};
         secondSyncA_ff <= {WIDE_BITS{1'b0}};
         secondSyncB_ff <= {WIDE_BITS{1'b0}};
         thirdSyncA_ff <= {NARROW_BITS{1'b0}};
         thirdSyncB_ff <= {NARROW_BITS{1'b0}};
      end else begin
         firstSyncA_ff <= firstPortIn;
         firstSyncB_ff <= firstSyncA_ff;
         secondSyncA_ff <= secondPortIn;
         secondSyncB_ff <= secondSyncA_ff;
         thirdSyncA_ff <= thirdPortIn;
         thirdSyncB_ff <= thirdSyncA_ff;
      end
   end

   // ***************************************
   // Write channel
   // ***************************************
   // Address and data are taken in either order and held until both are here
   // Ready falls while its half is held or a response waits: one write at a time
   assign s_axi_awready = !awHeld_ff && !bValid_ff;
   assign s_axi_wready = !wHeld_ff && !bValid_ff;
   assign doWrite = awHeld_ff && wHeld_ff && !bValid_ff;
   // Only an aligned, mapped write with lane 0 enabled reaches storage
   assign doStore = doWrite && wHit && wStrb_ff[0];
   assign wIdx = regIndex(awAddr_ff);
   assign wHit = (awAddr_ff[1:0] == 2'h0) && (wIdx != `UNUSED_GAP_IDX) && (wIdx <= `THIRD_PORT_DIRECTION_IDX);

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         awAddr_ff <= 5'h00;
         awHeld_ff <= 1'b0;
         wData_ff <= 32'h00000000;
         wStrb_ff <= 4'h0;
         wHeld_ff <= 1'b0;
         bValid_ff <= 1'b0;
         bResp_ff <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr_ff <= s_axi_awaddr;
            awHeld_ff <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
            wHeld_ff <= 1'b1;
         end
         // A refused address still answers, with DECERR, but stores nothing
         if (doWrite) begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            bValid_ff <= 1'b1;
            bResp_ff <= wHit ? `RESP_OKAY : `RESP_DECERR;
         end else if (bValid_ff && s_axi_bready) begin
            bValid_ff <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bValid_ff;
   assign s_axi_bresp = bResp_ff;

   // ***************************************
   // Data latches
   // ***************************************
   // No reset: latch contents survive reset, as software expects
   // Third latch keeps its two implemented bits; writes to the rest are dropped
   always @(posedge ref_clk) begin
      if (doStore) begin
         case (wIdx)
            `FIRST_PORT_LATCH_IDX: firstLatch_ff <= wData_ff[WIDE_BITS-1:0];
            `SECOND_PORT_LATCH_IDX: secondLatch_ff <= wData_ff[WIDE_BITS-1:0];
            `THIRD_PORT_LATCH_IDX: thirdLatch_ff <= wData_ff[NARROW_BITS-1:0];
            default: begin
            end
         endcase
      end
   end

   // ***************************************
   // Direction registers
   // ***************************************
   // Reset makes every pin an input; the third port has only bits 1 and 0
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         firstDir_ff <= `DIRECTION_RESET_WIDE;
         secondDir_ff <= `DIRECTION_RESET_WIDE;
         thirdDir_ff <= `DIRECTION_RESET_NARROW;
      end else if (doStore) begin
         case (wIdx)
            `FIRST_PORT_DIRECTION_IDX: firstDir_ff <= wData_ff[WIDE_BITS-1:0];
            `SECOND_PORT_DIRECTION_IDX: secondDir_ff <= wData_ff[WIDE_BITS-1:0];
            `THIRD_PORT_DIRECTION_IDX: thirdDir_ff <= wData_ff[NARROW_BITS-1:0];
            default: begin
            end
         endcase
      end
   end

   // ***************************************
   // Pin drivers and fault inputs
   // ***************************************
   // Latch reaches the pin only where the driver is on
   // Enables come straight from flops, so the pins see no decode glitch
   assign firstPortOe = firstDir_ff;
   assign secondPortOe = secondDir_ff;
   assign thirdPortOe = thirdDir_ff;
   assign firstPortOut = firstLatch_ff & firstDir_ff;
   assign secondPortOut = secondLatch_ff & secondDir_ff;
   assign thirdPortOut = thirdLatch_ff & thirdDir_ff;
   // Output bits force the fault line low (non-fault); inputs pass the pin
   assign motorFaultInput = thirdSyncB_ff & ~thirdDir_ff;

   // ***************************************
   // Read channel
   // ***************************************
   // Address decodes straight off the bus; a waiting answer holds arready low
   assign s_axi_arready = !rValid_ff;
   assign rIdx = regIndex(s_axi_araddr);

   // Read decode; unused bit positions stay zero
   always @* begin
      nxt_rData = 32'h00000000;
      nxt_rHit = (s_axi_araddr[1:0] == 2'h0);
      case (rIdx)
         `FIRST_PORT_LATCH_IDX: nxt_rData[WIDE_BITS-1:0] = pinView(firstLatch_ff, firstSyncB_ff, firstDir_ff);
         `SECOND_PORT_LATCH_IDX: nxt_rData[WIDE_BITS-1:0] = pinView(secondLatch_ff, secondSyncB_ff,
            secondDir_ff);
         `THIRD_PORT_LATCH_IDX: nxt_rData[NARROW_BITS-1:0] = (thirdLatch_ff & thirdDir_ff) |
            (thirdSyncB_ff & ~thirdDir_ff);
         `FIRST_PORT_DIRECTION_IDX: nxt_rData[WIDE_BITS-1:0] = firstDir_ff;
         `SECOND_PORT_DIRECTION_IDX: nxt_rData[WIDE_BITS-1:0] = secondDir_ff;
         `THIRD_PORT_DIRECTION_IDX: nxt_rData[NARROW_BITS-1:0] = thirdDir_ff;
         default: nxt_rHit = 1'b0;
      endcase
      // Refused reads return zero so no register leaks through
      if (!nxt_rHit) begin
         nxt_rData = 32'h00000000;
      end
   end

   // One-cycle read answer; data held until rready
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rValid_ff <= 1'b0;
         rData_ff <= 32'h00000000;
         rResp_ff <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rValid_ff <= 1'b1;
         rData_ff <= nxt_rData;
         rResp_ff <= nxt_rHit ? `RESP_OKAY : `RESP_DECERR;
      end else if (rValid_ff && s_axi_rready) begin
         rValid_ff <= 1'b0;
      end
   end

   assign s_axi_rvalid = rValid_ff;
   assign s_axi_rdata = rData_ff;
   assign s_axi_rresp = rResp_ff;

endmodule // three_port_parallel_io

// >>> tb/pin_board.sv
// Board model: resolves each pin wire from the block's drivers.
// Assumes the bench sets the outside levels on extLevel.
`timescale 1ns/1ns
module pin_board #(
   parameter W = 7
) (
   // From the block
   input wire [W-1:0] pinOut,
   input wire [W-1:0] pinOe,
   // Outside source and resolved wire
   input wire [W-1:0] extLevel,
   output wire [W-1:0] pinLevel
);
   // Driven bits carry the block's level, released bits the outside one
   assign pinLevel = (pinOut & pinOe) | (extLevel & ~pinOe);
endmodule // pin_board

// >>> tb/three_port_parallel_io_checker.sv
// Checker for the parallel I/O block: handshakes, pin drive, fault force.
// Assumes it is bound into the block and sees its ports only.
`timescale 1ns/1ns
module three_port_parallel_io_checker #(
   parameter WIDE_BITS = 7,
   parameter NARROW_BITS = 2
) (
   // Clock and reset
   input wire ref_clk,
   input wire resetn,
   // Bus handshakes
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // Bus payloads
   input wire [1:0] s_axi_bresp,
   input wire [1:0] s_axi_rresp,
   input wire [4:0] s_axi_araddr,
   input wire [31:0] s_axi_rdata,
   // Pins
   input wire [WIDE_BITS-1:0] firstPortOut,
   input wire [WIDE_BITS-1:0] firstPortOe,
   input wire [WIDE_BITS-1:0] secondPortOe,
   input wire [NARROW_BITS-1:0] thirdPortOe,
   input wire [NARROW_BITS-1:0] motorFaultInput
);
   // One domain, so clock and reset are given once
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_oe_reset: assert property ($rose(resetn) |-> firstPortOe == 0 && secondPortOe == 0 && thirdPortOe == 0)
      else $error("pins driven after reset");
   a_out_masked: assert property ((firstPortOut & ~firstPortOe) == 0)
      else $error("level on undriven pin");
   a_fault_force: assert property ((motorFaultInput & thirdPortOe) == 0)
      else $error("fault seen on output pin");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_turn: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
      ##[1:2] s_axi_bvalid) else $error("write answer late");
   a_gap_decerr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 5'h0c |=>
      s_axi_rresp == 2'h3 && s_axi_rdata == 0) else $error("gap read not refused");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:7] == 0)
      else $error("upper read bits set");
   // Main scenarios reached
   c_decerr: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
   c_fault_forced: cover property (thirdPortOe != 0);
   c_read_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule // three_port_parallel_io_checker

bind three_port_parallel_io three_port_parallel_io_checker
   #(.WIDE_BITS(WIDE_BITS), .NARROW_BITS(NARROW_BITS)) u_chk (.*);

// >>> tb/three_port_parallel_io_tb.sv
// Self-checking bench for the three-port parallel I/O block.
// Assumes the block, its header, the board model and checker come first.
`timescale 1ns/1ns
module three_port_parallel_io_tb;
   logic ref_clk = 0, resetn = 0;
   logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0] s_axi_wstrb = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [6:0] firstPortIn, firstPortOut, firstPortOe, secondPortIn, secondPortOut, secondPortOe;
   wire [1:0] thirdPortIn, thirdPortOut, thirdPortOe, motorFaultInput;
   logic [6:0] aExt = 0, bExt = 0;
   logic [1:0] cExt = 0;
   int err_total = 0, n_tests = 0, cyc = 0;

   three_port_parallel_io u_three_port_parallel_io (.*);
   pin_board #(.W(7)) u_pin_board_a (.pinOut(firstPortOut), .pinOe(firstPortOe),
      .extLevel(aExt), .pinLevel(firstPortIn));
   pin_board #(.W(7)) u_pin_board_b (.pinOut(secondPortOut), .pinOe(secondPortOe),
      .extLevel(bExt), .pinLevel(secondPortIn));
   pin_board #(.W(2)) u_pin_board_c (.pinOut(thirdPortOut), .pinOe(thirdPortOe),
      .extLevel(cExt), .pinLevel(thirdPortIn));

   always #5 ref_clk = ~ref_clk;

   // Hang guard, far above the hundred-odd cycles the run needs
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Bus write; each task starts one edge on so no signal is set twice at once
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 0;
      chk("bresp", er, s_axi_bresp);
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er, input string what);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 0;
      chk(what, ed, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
   endtask

   task automatic t_reset();
      chk("oe", 0, {firstPortOe, secondPortOe, thirdPortOe});
      rd(5'h10, 0, 0, "dirA");
      rd(5'h14, 0, 0, "dirB");
      rd(5'h18, 0, 0, "dirC");
   endtask

   // Latch loaded before direction, upper three pins made outputs
   task automatic t_wide(input logic [4:0] a);
      aExt <= 7'h55;
      bExt <= 7'h55;
      repeat (3) @(posedge ref_clk);
      rd(a, 32'h55, 0, "pins");
      wr(a, 32'h2a, 4'hf, 0);
      rd(a, 32'h55, 0, "inLatch");
      wr(a + 5'h10, 32'hf0, 4'hf, 0);
      rd(a + 5'h10, 32'h70, 0, "dir");
      rd(a, 32'h25, 0, "mixed");
      chk("oe", 7'h70, a[2] ? secondPortOe : firstPortOe);
      chk("out", 7'h20, a[2] ? secondPortOut : firstPortOut);
   endtask

   task automatic t_portc();
      cExt <= 2'h3;
      repeat (3) @(posedge ref_clk);
      rd(5'h08, 32'h3, 0, "pinsC");
      chk("fault", 2'h3, motorFaultInput);
      wr(5'h08, 32'hfc, 4'hf, 0);
      wr(5'h18, 32'hfd, 4'hf, 0);
      rd(5'h18, 32'h1, 0, "dirC");
      rd(5'h08, 32'h2, 0, "mixC");
      chk("fault", 2'h2, motorFaultInput);
      chk("oeC", 2'h1, thirdPortOe);
      chk("outC", 2'h0, thirdPortOut);
      wr(5'h08, 32'h3, 4'hf, 0);
      chk("outC", 2'h1, thirdPortOut);
      wr(5'h18, 0, 4'hf, 0);
      repeat (3) @(posedge ref_clk);
      chk("fault", 2'h3, motorFaultInput);
   endtask

   task automatic t_decode();
      wr(5'h0c, 32'hff, 4'hf, 2'h3);
      rd(5'h0c, 0, 2'h3, "gap");
      rd(5'h11, 0, 2'h3, "misaligned");
      wr(5'h11, 0, 4'hf, 2'h3);
      wr(5'h10, 0, 4'h0, 0);
      rd(5'h10, 32'h70, 0, "noStrobe");
   endtask

   // Mid-run reset clears directions but keeps the port A latch
   task automatic t_rereset();
      @(posedge ref_clk);
      resetn <= 0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1;
      t_reset();
      wr(5'h10, 32'h7f, 4'hf, 0);
      rd(5'h00, 32'h2a, 0, "keptA");
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge ref_clk);
      resetn <= 1;
      t_reset();
      t_wide(5'h00);
      t_wide(5'h04);
      t_portc();
      t_decode();
      t_rereset();
      report_and_stop();
   end
endmodule // three_port_parallel_io_tb
